// File: hw/srx_ramp_ctrl.sv
/*
  ramp-up / ramp-down pulse width profile, sensor overdrive and reversal
  wait of the stepper sequencer, with their register bytes.
  assumes the sequencer issues step_tick per step, rot_tick per full
  rotation, op_done when its count is used up and rev_req when a reversal
  (auto or interrupt) is due; all inputs are synchronous to clock.
*/
//
// How it works
// - sixteen-bit ccw rotation count at 20h/21h
// - overdrive byte per sensor irq, 22h/23h
// - overdrive ignored unless both enables set
// - overdrive keeps turning, same direction
// - zero overdrive count means no overdrive
// - overdrive unit: steps, or rotations if set
// - ramp bits: up bit5, down bit4
// - ramp factor code 0 to 13 gives 2^D multiplier
// - width changes by range step times multiplier
// - ramps start and end at range maximum
// - ramp-up shortens width down to target
// - ramp-down lengthens width to range maximum
// - irq latched in ramps, acted after ramp-up only
// - only host stop acts during ramps
// - ramp-up stop: hard, ramp-down, else stop
// - ramp-down stop: hard stops, else continue
// - interrupt controls act between the ramps
// - idle loop delay before each reversal
// - loop delay byte at 25h, seconds
// - top three width bits pick prescaler range
// - hard stop only for host stop requests
`default_nettype none
`include "srx_consts.svh"
module srx_ramp_ctrl #(
  parameter int unsigned CYC_PER_SEC = `SRX_CLK_HZ * `SRX_WAIT_UNIT_S
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire srx_pkg::srx_regreq_s reg_req,       // register write port
  input  wire logic [7:0]          reg_rd_addr,   // register read offset
  input  wire srx_pkg::srx_motor_s motor_cfg,     // sequencer settings
  input  wire logic                sensor_irq_a,  // irq a event pulse
  input  wire logic                sensor_irq_b,  // irq b event pulse
  input  wire logic                step_tick,     // one step issued
  input  wire logic                rot_tick,      // one rotation finished
  input  wire logic                op_done,       // step/rotation count used
  input  wire logic                rev_req,       // reversal due
  output logic [7:0]               reg_rd_data,   // read byte, one cycle late
  output logic [15:0]              ccw_rot_count, // rotation count word
  output logic [15:0]              pulse_width,   // active width word
  output logic                     dir_ccw,       // active direction
  output logic [5:0]               phase,         // one-hot motion phase
  output logic                     od_done,       // overdrive finished pulse
  output logic                     stopped        // motion ended pulse
);

  // function: ramp step in width codes for a factor code
  function automatic logic [13:0] ramp_mult(input logic [3:0] factor);
    ramp_mult = 14'h0001 << factor;
  endfunction : ramp_mult

  // register bytes
  logic [15:0] rot_reg,  rot_next;   // ccw rotation count
  logic [7:0]  oda_reg,  oda_next;   // overdrive count, irq a
  logic [7:0]  odb_reg,  odb_next;   // overdrive count, irq b
  logic [5:0]  ramp_reg, ramp_next;  // ramp control, bits 7:6 absent
  logic [7:0]  wait_reg, wait_next;  // loop delay seconds
  logic [7:0]  rd_reg,   rd_next;    // read data

  // motion state
  srx_pkg::srx_state_e state_reg, state_next;
  logic [12:0] code_reg,  code_next; // width code within range
  logic        dir_reg,   dir_next;
  logic [2:0]  presc_reg, presc_next; // prescaler of the active direction
  logic        run_q_reg;            // last run bit, for edges
  logic [1:0]  pend_reg,  pend_next; // latched irq a/b
  logic [7:0]  odc_reg,   odc_next;  // overdrive units left
  logic        odu_reg,   odu_next;  // overdrive counts rotations
  logic [5:0]  rcfg_reg,  rcfg_next; // ramp setup frozen at start
  logic        odd_reg,   odd_next;
  logic        stp_reg,   stp_next;
  logic        wait_go;              // start the reversal wait
  logic        wait_done;

  // working terms
  logic        start_req, stop_req;
  logic [15:0] target_pw;
  logic [12:0] target;
  logic [14:0] dn_sum;               // code plus step, may overflow
  logic [14:0] up_dif;               // code minus step, may go negative
  logic [12:0] code_up, code_dn;
  logic [1:0]  pend_all;
  logic        od_a_ok, od_b_ok;

  srx_wait_timer #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_wait (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (wait_go),
    .seconds (wait_reg),
    .done    (wait_done)
  );

  // register writes and registered read answer
  always_comb
  begin
    rot_next  = rot_reg;
    oda_next  = oda_reg;
    odb_next  = odb_reg;
    ramp_next = ramp_reg;
    wait_next = wait_reg;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `SRX_OFS_CCW_ROT_LO: rot_next[7:0]  = reg_req.wdata;
        `SRX_OFS_CCW_ROT_HI: rot_next[15:8] = reg_req.wdata;
        `SRX_OFS_OD_CNT_A:   oda_next = reg_req.wdata;
        `SRX_OFS_OD_CNT_B:   odb_next = reg_req.wdata;
        `SRX_OFS_RAMP_CTRL:  ramp_next = reg_req.wdata[5:0];
        `SRX_OFS_REV_WAIT:   wait_next = reg_req.wdata;
        default:             rot_next = rot_reg;
      endcase
    end
    case (reg_rd_addr)
      `SRX_OFS_CCW_ROT_LO: rd_next = rot_reg[7:0];
      `SRX_OFS_CCW_ROT_HI: rd_next = rot_reg[15:8];
      `SRX_OFS_OD_CNT_A:   rd_next = oda_reg;
      `SRX_OFS_OD_CNT_B:   rd_next = odb_reg;
      `SRX_OFS_RAMP_CTRL:  rd_next = {2'b00, ramp_reg} & `SRX_RAMP_WR_MASK;
      `SRX_OFS_REV_WAIT:   rd_next = wait_reg;
      default:             rd_next = 8'h00; // unmapped reads zero
    endcase
  end

  // width arithmetic; the range step is one code of the active prescaler
  always_comb
  begin
    target_pw = dir_reg ? motor_cfg.ccw_pw : motor_cfg.cw_pw;
    target    = target_pw[12:0];
    up_dif    = {2'b00, code_reg} - {1'b0, ramp_mult(rcfg_reg[3:0])};
    dn_sum    = {2'b00, code_reg} + {1'b0, ramp_mult(rcfg_reg[3:0])};
    // clamp so the ramp never overshoots its end point
    if (up_dif[14] || (up_dif[12:0] < target) || (up_dif[13]))
      code_up = target;
    else
      code_up = up_dif[12:0];
    if (dn_sum > {2'b00, `SRX_PW_CODE_MAX})
      code_dn = `SRX_PW_CODE_MAX;
    else
      code_dn = dn_sum[12:0];
    start_req = motor_cfg.run & ~run_q_reg;
    stop_req  = ~motor_cfg.run & run_q_reg; // host stop only
    pend_all  = pend_reg | {sensor_irq_b, sensor_irq_a};
    // overdrive honoured only with both enables and a nonzero count
    od_a_ok = motor_cfg.irq_ctrl_en & motor_cfg.od_sel[0] & (oda_reg != 8'h00);
    od_b_ok = motor_cfg.irq_ctrl_en & motor_cfg.od_sel[1] & (odb_reg != 8'h00);
  end

  // motion sequencer
  always_comb
  begin
    state_next = state_reg;
    code_next  = code_reg;
    dir_next   = dir_reg;
    odc_next   = odc_reg;
    odu_next   = odu_reg;
    rcfg_next  = rcfg_reg;
    odd_next   = 1'b0;
    stp_next   = 1'b0;
    wait_go    = 1'b0;
    // events are latched by default; idle clears them, run does unless it is ending, and a clear drops any new one
    pend_next  = pend_reg | {sensor_irq_b, sensor_irq_a};
    case (state_reg)
      srx_pkg::ST_IDLE:
      begin
        pend_next = 2'b00;
        if (start_req)
        begin
          rcfg_next = ramp_reg;
          dir_next  = 1'b0; // every run starts clockwise
          if (ramp_reg[`SRX_RAMP_UP_BIT])
          begin
            state_next = srx_pkg::ST_RUP;
            code_next  = `SRX_PW_CODE_MAX;
          end
          else
          begin
            state_next = srx_pkg::ST_RUN;
            code_next  = target;
          end
        end
      end
      srx_pkg::ST_RUP:
      begin
        // interrupts wait; only a host stop is looked at
        if (stop_req)
        begin
          if (motor_cfg.hard_stop)
          begin
            state_next = srx_pkg::ST_IDLE;
            stp_next   = 1'b1;
          end
          else if (rcfg_reg[`SRX_RAMP_DN_BIT])
            state_next = srx_pkg::ST_RDN;
          else
          begin
            state_next = srx_pkg::ST_IDLE;
            stp_next   = 1'b1;
          end
        end
        else if (code_reg <= target)
          state_next = srx_pkg::ST_RUN;
        else if (step_tick)
          code_next = code_up;
      end
      srx_pkg::ST_RUN:
      begin
        code_next = target;
        if (stop_req || op_done)
        begin
          if (stop_req && motor_cfg.hard_stop)
          begin
            state_next = srx_pkg::ST_IDLE;
            stp_next   = 1'b1;
          end
          else if (rcfg_reg[`SRX_RAMP_DN_BIT])
            state_next = srx_pkg::ST_RDN;
          else
          begin
            state_next = srx_pkg::ST_IDLE;
            stp_next   = 1'b1;
          end
        end
        else if ((pend_all[0] && od_a_ok) || (pend_all[1] && od_b_ok))
        begin
          // irq a first when both are pending; direction stays
          state_next = srx_pkg::ST_OVER;
          odc_next   = (pend_all[0] && od_a_ok) ? oda_reg : odb_reg;
          odu_next   = motor_cfg.od_unit_rot;
          pend_next  = 2'b00;
        end
        else if (rev_req)
        begin
          state_next = srx_pkg::ST_WAIT;
          wait_go    = 1'b1;
          pend_next  = 2'b00;
        end
        else
          pend_next = 2'b00; // other irq actions belong to the sequencer
      end
      srx_pkg::ST_RDN:
      begin
        if (stop_req && motor_cfg.hard_stop)
        begin
          state_next = srx_pkg::ST_IDLE;
          stp_next   = 1'b1;
        end
        else if (code_reg == `SRX_PW_CODE_MAX)
        begin
          state_next = srx_pkg::ST_IDLE;
          stp_next   = 1'b1;
        end
        else if (step_tick)
          code_next = code_dn;
      end
      srx_pkg::ST_OVER:
      begin
        // keep the same direction and width until the count runs out
        if (stop_req)
        begin
          state_next = srx_pkg::ST_IDLE;
          stp_next   = 1'b1;
        end
        else if (odc_reg == 8'h00)
        begin
          state_next = srx_pkg::ST_IDLE;
          odd_next   = 1'b1;
          stp_next   = 1'b1;
        end
        else if (odu_reg ? rot_tick : step_tick)
          odc_next = odc_reg - 8'h01;
      end
      srx_pkg::ST_WAIT:
      begin
        // motor idles; a host stop still ends the run
        if (stop_req)
        begin
          state_next = srx_pkg::ST_IDLE;
          stp_next   = 1'b1;
        end
        else if (wait_done)
        begin
          state_next = srx_pkg::ST_RUN;
          dir_next   = ~dir_reg;
        end
      end
      default:
        state_next = srx_pkg::ST_IDLE;
    endcase
    // taken with the next direction so the output can come from a flip-flop
    presc_next = dir_next ? motor_cfg.ccw_pw[15:13] : motor_cfg.cw_pw[15:13];
  end

  // registers only
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rot_reg   <= {`SRX_RST_BYTE, `SRX_RST_BYTE};
      oda_reg   <= `SRX_RST_BYTE;
      odb_reg   <= `SRX_RST_BYTE;
      ramp_reg  <= 6'h00;
      wait_reg  <= `SRX_RST_BYTE;
      rd_reg    <= 8'h00;
      state_reg <= srx_pkg::ST_IDLE;
      code_reg  <= `SRX_PW_CODE_MAX;
      dir_reg   <= 1'b0;
      presc_reg <= 3'h0;
      run_q_reg <= 1'b0;
      pend_reg  <= 2'b00;
      odc_reg   <= 8'h00;
      odu_reg   <= 1'b0;
      rcfg_reg  <= 6'h00;
      odd_reg   <= 1'b0;
      stp_reg   <= 1'b0;
    end
    else
    begin
      rot_reg   <= rot_next;
      oda_reg   <= oda_next;
      odb_reg   <= odb_next;
      ramp_reg  <= ramp_next;
      wait_reg  <= wait_next;
      rd_reg    <= rd_next;
      state_reg <= state_next;
      code_reg  <= code_next;
      dir_reg   <= dir_next;
      presc_reg <= presc_next;
      run_q_reg <= motor_cfg.run;
      pend_reg  <= pend_next;
      odc_reg   <= odc_next;
      odu_reg   <= odu_next;
      rcfg_reg  <= rcfg_next;
      odd_reg   <= odd_next;
      stp_reg   <= stp_next;
    end
  end

  // outputs straight from flip-flops; prescaler follows active direction
  assign reg_rd_data   = rd_reg;
  assign ccw_rot_count = rot_reg;
  assign pulse_width   = {presc_reg, code_reg};
  assign dir_ccw       = dir_reg;
  assign phase         = state_reg;
  assign od_done       = odd_reg;
  assign stopped       = stp_reg;

endmodule : srx_ramp_ctrl
`default_nettype wire

// File: hw/srx_consts.svh
/*
  offsets, field positions, reset values and timing figures of the ramp,
  overdrive and reversal-wait block.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

`define SRX_OFS_CCW_ROT_LO  8'h20
`define SRX_OFS_CCW_ROT_HI  8'h21
`define SRX_OFS_OD_CNT_A    8'h22
`define SRX_OFS_OD_CNT_B    8'h23
`define SRX_OFS_RAMP_CTRL   8'h24
`define SRX_OFS_REV_WAIT    8'h25

`define SRX_RST_BYTE        8'h00
`define SRX_RAMP_UP_BIT     5
`define SRX_RAMP_DN_BIT     4
`define SRX_RAMP_WR_MASK    8'h3f
`define SRX_FACTOR_MAX      4'hd

`define SRX_PW_CODE_MAX     13'h1fff
`define SRX_CLK_HZ          20000000
`define SRX_WAIT_UNIT_S     1

`endif

// File: hw/srx_pkg.sv
/*
  types shared by the ramp, overdrive and reversal-wait block.
  assumes srx_consts.svh is on the include path.
*/
`default_nettype none
`include "srx_consts.svh"
package srx_pkg;

  // motion phase, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RUP   = 6'h02,
    ST_RUN   = 6'h04,
    ST_RDN   = 6'h08,
    ST_OVER  = 6'h10,
    ST_WAIT  = 6'h20
  } srx_state_e;

  // register port request
  typedef struct packed {
    logic       wr;    // write strobe, one cycle
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write byte
  } srx_regreq_s;

  // settings and status held by the rest of the sequencer
  typedef struct packed {
    logic        run;        // start/stop bit of motor_control
    logic        hard_stop;  // hard stop enable of motor_control
    logic        irq_ctrl_en;// interrupt-driven control enabled
    logic [1:0]  od_sel;     // overdrive_select_setup bits, [0]=irq a
    logic        od_unit_rot;// interrupt_action_setup bit 4
    logic [15:0] cw_pw;      // cw_pulse_width word
    logic [15:0] ccw_pw;     // ccw_pulse_width word
  } srx_motor_s;

endpackage : srx_pkg
`default_nettype wire

// File: hw/srx_wait_timer.sv
/*
  whole-second wait timer used to idle the motor before a reversal.
  assumes a free-running clock of CYC_PER_SEC cycles per second.
*/
`default_nettype none
`include "srx_consts.svh"
module srx_wait_timer #(
  parameter int unsigned CYC_PER_SEC = `SRX_CLK_HZ * `SRX_WAIT_UNIT_S
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [7:0] seconds,
  output logic            done
);

  logic [7:0]  sec_reg,  sec_next;   // whole seconds still to wait
  logic [31:0] tick_reg, tick_next;  // cycles left in this second
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;

  // count down seconds; zero seconds finishes on the next edge
  always_comb
  begin
    sec_next  = sec_reg;
    tick_next = tick_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start)
    begin
      sec_next  = seconds;
      tick_next = CYC_PER_SEC - 32'h1;
      busy_next = (seconds != 8'h00);
      done_next = (seconds == 8'h00);
    end
    else if (busy_reg)
    begin
      if (tick_reg != 32'h0)
        tick_next = tick_reg - 32'h1;
      else if (sec_reg == 8'h01)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        sec_next  = sec_reg - 8'h01;
        tick_next = CYC_PER_SEC - 32'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sec_reg  <= 8'h00;
      tick_reg <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      sec_reg  <= sec_next;
      tick_reg <= tick_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule : srx_wait_timer
`default_nettype wire

// File: verif/srx_ramp_ctrl_asserts.sv
/*
  port checker of the ramp, overdrive and reversal-wait block.
  assumes it is bound into srx_ramp_ctrl and sees only its ports.
*/
`default_nettype none
module srx_ramp_ctrl_asserts #(
  parameter int unsigned CYC_PER_SEC = 10
) (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire srx_pkg::srx_motor_s motor_cfg,
  input wire logic                step_tick,
  input wire logic [7:0]          reg_rd_addr,
  input wire logic [7:0]          reg_rd_data,
  input wire logic [15:0]         pulse_width,
  input wire logic                dir_ccw,
  input wire logic [5:0]          phase,
  input wire logic                stopped
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // code and target of the active direction
  wire [12:0] code = pulse_width[12:0];
  wire [12:0] tgt  = dir_ccw ? motor_cfg.ccw_pw[12:0] : motor_cfg.cw_pw[12:0];

  AST_UP_STEP:
    assert property (phase == 6'h02 && step_tick && motor_cfg.run && code > tgt
      |=> code < $past(code) && code >= $past(tgt)) else $error("bad ramp-up step");
  AST_UP_END:
    assert property (phase == 6'h02 && motor_cfg.run && code <= tgt |=> phase == 6'h04)
    else $error("ramp-up did not end");
  AST_UP_HOLD:
    assert property (phase == 6'h02 && motor_cfg.run |=> phase inside {6'h02, 6'h04})
    else $error("ramp-up disturbed");
  AST_DN_STEP:
    assert property (phase == 6'h08 && step_tick && code != 13'h1fff && !motor_cfg.hard_stop
      |=> code > $past(code)) else $error("bad ramp-down step");
  AST_DN_END:
    assert property (phase == 6'h08 && code == 13'h1fff |=> phase == 6'h01 && stopped)
    else $error("ramp-down did not end");
  AST_HARD:
    assert property ((phase == 6'h02 || phase == 6'h08) && motor_cfg.hard_stop
      && $fell(motor_cfg.run) |=> phase == 6'h01) else $error("hard stop ignored");
  AST_OD_DIR:
    assert property (phase == 6'h10 |=> phase != 6'h10 || $stable(dir_ccw))
    else $error("overdrive turned direction");
  AST_REV:
    assert property ($changed(dir_ccw) |-> phase == 6'h01 || $past(phase) inside {6'h01, 6'h20})
    else $error("reversal without wait");
  AST_PRESC:
    assert property (pulse_width[15:13] == (dir_ccw ? $past(motor_cfg.ccw_pw[15:13])
      : $past(motor_cfg.cw_pw[15:13]))) else $error("wrong prescaler");
  AST_RSVD:
    assert property (reg_rd_addr == 8'h24 |=> reg_rd_data[7:6] == 2'b00)
    else $error("reserved bits not zero");
endmodule : srx_ramp_ctrl_asserts

bind srx_ramp_ctrl srx_ramp_ctrl_asserts #(.CYC_PER_SEC(CYC_PER_SEC)) srx_ramp_ctrl_asserts_inst (
  .clock(clock), .sys_rst(sys_rst), .motor_cfg(motor_cfg), .step_tick(step_tick),
  .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .pulse_width(pulse_width),
  .dir_ccw(dir_ccw), .phase(phase), .stopped(stopped)
);
`default_nettype wire

// File: verif/srx_host_model.sv
/*
  host model: writes and reads the register bytes of the block.
  assumes writes land in the strobe cycle and reads answer one cycle late.
*/
`default_nettype none
module srx_host_model (
  input  wire logic                 clock,
  output var  srx_pkg::srx_regreq_s reg_req,
  output var  logic [7:0]           reg_rd_addr,
  input  wire logic [7:0]           reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_req = '0;
    reg_rd_addr = 8'h00;
  end

  // one-cycle strobe; callers never send factor codes 1110 or 1111
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    // released fields scrambled so a late sample shows up
    reg_req <= '{wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // read data is taken once settled after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd_addr <= a;
    @(posedge clock);
    #1;
    d = reg_rd_data;
  endtask : rd
endmodule : srx_host_model
`default_nettype wire

// File: verif/srx_ramp_ctrl_bench.sv
/*
  self-checking bench of the ramp, overdrive and reversal-wait block.
  assumes the host model and the checker are compiled before it.
*/
`default_nettype none
module srx_ramp_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clock = 1'b0;
  logic                 sys_rst = 1'b1;
  srx_pkg::srx_motor_s  motor_cfg = '0;
  logic [5:0]           ev = 6'h00;   // step, irq a, irq b, done, rev, rot
  srx_pkg::srx_regreq_s reg_req;
  logic [7:0]           reg_rd_addr, reg_rd_data;
  logic [15:0]          ccw_rot_count, pulse_width;
  logic [5:0]           phase;
  logic                 dir_ccw, od_done, stopped;
  int                   bad_count = 0;
  int                   cmp_count = 0;

  always #25 clock = ~clock;

  // one second shortened to ten cycles
  srx_ramp_ctrl #(.CYC_PER_SEC(10)) srx_ramp_ctrl_inst (
    .clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rd_addr(reg_rd_addr),
    .motor_cfg(motor_cfg), .sensor_irq_a(ev[1]), .sensor_irq_b(ev[2]), .step_tick(ev[0]),
    .rot_tick(ev[5]), .op_done(ev[3]), .rev_req(ev[4]), .reg_rd_data(reg_rd_data),
    .ccw_rot_count(ccw_rot_count), .pulse_width(pulse_width), .dir_ccw(dir_ccw),
    .phase(phase), .od_done(od_done), .stopped(stopped)
  );
  srx_host_model srx_host_model_inst (
    .clock(clock), .reg_req(reg_req), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data)
  );

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // n edges, then let their updates settle
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt

  // one-cycle pulse on event line w
  task automatic hit(input int w);
    @(posedge clock);
    ev <= 6'h01 << w;
    @(posedge clock);
    ev <= 6'h00;
    #1;
  endtask : hit

  task automatic run_to(input logic r);
    @(posedge clock);
    motor_cfg.run <= r;
    wt(1);
  endtask : run_to

  task automatic wait_ph(input logic [5:0] exp, input int n);
    for (int i = 0; i < n && phase !== exp; i++)
      wt(1);
    chk("phase", 16'(phase), 16'(exp));
  endtask : wait_ph

  // ramp setup is frozen at start, so it is written first; the run bit is
  // dropped for a cycle since only its rising edge starts a run, and a run can end with it still set
  task automatic go(input logic [7:0] rc, input logic [15:0] pw, input logic hs);
    srx_host_model_inst.wr(8'h24, rc);
    motor_cfg.run <= 1'b0;
    motor_cfg.cw_pw <= pw;
    motor_cfg.hard_stop <= hs;
    run_to(1'b1);
  endtask : go

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] v;
    for (int a = 'h1f; a < 'h27; a++)
    begin
      srx_host_model_inst.rd(8'(a), d);
      chk("reset value", 16'(d), 16'h0000);
      srx_host_model_inst.wr(8'(a), 8'(a) ^ 8'hc5);
    end
    for (int a = 'h1f; a < 'h27; a++)
    begin
      v = (a < 'h20 || a > 'h25) ? 8'h00
        : (8'(a) ^ 8'hc5) & ((a == 'h24) ? 8'h3f : 8'hff);
      srx_host_model_inst.rd(8'(a), d);
      chk("register", 16'(d), 16'(v));
    end
    chk("rotations", ccw_rot_count, 16'he4e5);
  endtask : t_regs

  // factor codes 0 to 13, one step from range maximum toward target zero;
  // ramp-down is enabled too, so the hard stop must win over it
  task automatic t_factor();
    for (int d = 0; d < 14; d++)
    begin
      go(8'h30 | 8'(d), 16'h0000, 1'b1);
      chk("ramp start", pulse_width, 16'h1fff);
      hit(0);
      chk("ramp step", pulse_width, (d == 13) ? 16'h0000 : 16'h1fff - (16'h0001 << d));
      run_to(1'b0);
      chk("hard stop", 16'(phase), 16'h0001);
    end
  endtask : t_factor

  task automatic t_stops();
    go(8'h30, 16'h1ffc, 1'b0);
    hit(0);
    run_to(1'b0);
    chk("soft stop", 16'(phase), 16'h0008);
    hit(0);
    chk("ramp back", pulse_width, 16'h1fff);
    wait_ph(6'h01, 2);
    go(8'h20, 16'h1ffc, 1'b0);
    run_to(1'b0);
    chk("plain stop", 16'(phase), 16'h0001);
    go(8'h10, 16'h1ffc, 1'b0);
    chk("no ramp-up", pulse_width, 16'h1ffc);
    hit(3);
    wait_ph(6'h08, 2);
    run_to(1'b0);
    chk("soft in down", 16'(phase), 16'h0008);
    repeat (3) hit(0);
    wait_ph(6'h01, 2);
    go(8'h10, 16'h1ffc, 1'b1);
    hit(3);
    hit(0);
    run_to(1'b0);
    chk("hard in down", 16'(phase), 16'h0001);
  endtask : t_stops

  task automatic t_irq();
    srx_host_model_inst.wr(8'h22, 8'h02);
    srx_host_model_inst.wr(8'h23, 8'h00);
    motor_cfg.irq_ctrl_en <= 1'b1;
    motor_cfg.od_sel <= 2'b11;
    go(8'h20, 16'h1ffe, 1'b1);
    hit(1);
    chk("irq held", 16'(phase), 16'h0002);
    hit(0);
    wait_ph(6'h10, 3);
    hit(0);
    chk("over dir", 16'({phase, dir_ccw}), 16'h0020);
    hit(0);
    wait_ph(6'h01, 2);
    chk("od end", 16'({od_done, stopped}), 16'h0003);
    go(8'h00, 16'h1ffe, 1'b1);
    hit(2);
    wt(2);
    chk("zero count", 16'(phase), 16'h0004);
    @(posedge clock);
    motor_cfg.od_sel <= 2'b10;
    hit(1);
    wt(2);
    chk("od off", 16'(phase), 16'h0004);
    @(posedge clock);
    motor_cfg.od_sel <= 2'b11;
    motor_cfg.irq_ctrl_en <= 1'b0;
    hit(1);
    wt(2);
    chk("irq off", 16'(phase), 16'h0004);
    @(posedge clock);
    motor_cfg.irq_ctrl_en <= 1'b1;
    motor_cfg.od_unit_rot <= 1'b1;
    hit(1);
    wait_ph(6'h10, 3);
    repeat (2) hit(0);
    chk("rot unit", 16'(phase), 16'h0010);
    repeat (2) hit(5);
    wait_ph(6'h01, 2);
  endtask : t_irq

  task automatic t_rev();
    int n;
    @(posedge clock);
    motor_cfg.ccw_pw <= 16'he005;
    go(8'h00, 16'h0005, 1'b0);
    for (int s = 2; s >= 0; s -= 2)
    begin
      srx_host_model_inst.wr(8'h25, 8'(s));
      hit(4);
      n = 0;
      while (phase === 6'h20 && n < 100)
      begin
        wt(1);
        n++;
      end
      chk("wait span", 16'(n >= s * 10 && n <= s * 10 + 3), 16'h0001);
      wt(1);
      chk("turned", 16'({phase, dir_ccw}), (s > 0) ? 16'h0009 : 16'h0008);
      chk("width", pulse_width, (s > 0) ? 16'he005 : 16'h0005);
    end
    run_to(1'b0);
  endtask : t_rev

  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_factor();
    t_stops();
    t_irq();
    t_rev();
    complete_run();
  end

  // watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run();
  end
endmodule : srx_ramp_ctrl_bench
`default_nettype wire
